// *** verilog/pcc_defines.vh ***
// constants for the protection, cache and lockdown control registers
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
// primary register numbers
`define PCC_PRI_CTRL      4'h1
`define PCC_PRI_REGION    4'h6
`define PCC_PRI_CACHEOP   4'h7
`define PCC_PRI_LOCKTCM   4'h9
`define PCC_PRI_COMPAT    4'hF
// secondary register field values
`define PCC_SEC_C0        4'h0
`define PCC_SEC_C1        4'h1
`define PCC_SEC_C5        4'h5
`define PCC_SEC_C6        4'h6
`define PCC_SEC_C8        4'h8
`define PCC_SEC_C10       4'hA
`define PCC_SEC_C13       4'hD
`define PCC_SEC_C14       4'hE
// operation selector values
`define PCC_SEL0          3'h0
`define PCC_SEL1          3'h1
`define PCC_SEL2          3'h2
`define PCC_SEL4          3'h4
// field positions
`define PCC_BASE_RANGE    31:12
`define PCC_SIZE_RANGE    5:1
`define PCC_EN_BIT        0
`define PCC_LOAD_BIT      31
`define PCC_SEG_RANGE     1:0
`define PCC_IDXSEG_RANGE  31:30
`define PCC_IDX_LSB       5
`define PCC_PROT_EN_BIT   0
// size codes: 4KB lowest legal, shift adds one
`define PCC_SIZE_MIN      5'h0B
`define PCC_SIZE_SHIFT    6'h01
`define PCC_ALL_ONES      32'hFFFFFFFF
`define PCC_ZERO32        32'h00000000
`define PCC_BASE_RESET    20'h00000
// cache operation codes driven to the cache controllers
`define PCC_OP_NONE       4'h0
`define PCC_OP_IFLUSH_ALL 4'h1
`define PCC_OP_IFLUSH_ADR 4'h2
`define PCC_OP_IPREFETCH  4'h3
`define PCC_OP_DFLUSH_ALL 4'h4
`define PCC_OP_DFLUSH_ADR 4'h5
`define PCC_OP_DCLEAN_ADR 4'h6
`define PCC_OP_DCLFL_ADR  4'h7
`define PCC_OP_DCLEAN_IDX 4'h8
`define PCC_OP_DCLFL_IDX  4'h9
`endif

// *** verilog/pcc_regs.v ***
// protection region, cache operation, lockdown and tcm region registers
`timescale 1ns/1ns
`default_nettype none
`include "pcc_defines.vh"

module pcc_regs #(
  parameter IDX_TOP = 9
) (
  input  wire                   mclk,
  input  wire                   srst,
  input  wire                   cpWrite,
  input  wire                   cpRead,
  input  wire [3:0]             cpPrimary,
  input  wire [3:0]             cpSecondary,
  input  wire [2:0]             cpSelector,
  input  wire [31:0]            cpWdata,
  output reg  [31:0]            cpRdata_ff,
  output reg                    cpRdValid_ff,
  output reg                    cpStall_ff,
  input  wire                   fast_irq_request_n,
  input  wire                   normal_irq_request_n,
  input  wire                   external_debug_request,
  input  wire                   debug_permit,
  input  wire                   debugReqBit,
  input  wire                   linefetchBusy,
  input  wire                   wbEmpty,
  input  wire [4:0]             dtcmSizeStrap,
  input  wire [4:0]             itcmSizeStrap,
  input  wire [31:0]            chkAddr,
  output reg  [7:0]             chkHit_ff,
  output reg                    protEnable_ff,
  output reg                    cacheOpValid_ff,
  output reg  [3:0]             cacheOpCode_ff,
  output reg  [31:0]            cacheOpAddr_ff,
  output reg  [1:0]             cacheOpSegment_ff,
  output reg  [IDX_TOP-5:0]     cacheOpIndex_ff,
  output reg                    wbDrainReq_ff,
  output reg                    coreHalt_ff,
  output reg                    lowPower_ff,
  output reg                    enterDebug_ff,
  output reg                    irqWake_ff,
  output reg                    dLockLoad_ff,
  output reg  [1:0]             dLockSeg_ff,
  output reg                    iLockLoad_ff,
  output reg  [1:0]             iLockSeg_ff,
  output reg  [19:0]            dtcmBase_ff,
  output reg  [4:0]             dtcmSize_ff,
  output reg  [4:0]             itcmSize_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // states of the command sequencer
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_PEND  = 2'b01;
  localparam [1:0] ST_DRAIN = 2'b10;
  localparam [1:0] ST_WFI   = 2'b11;

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [19:0] regBase_ff [0:7];
  reg  [4:0]  regSize_ff [0:7];
  reg  [7:0]  regEn_ff;
  reg  [3:0]  pendOp_ff;
  reg  [3:0]  nxt_pendOp;
  reg  [31:0] pendData_ff;
  reg  [31:0] rdMux;
  reg  [3:0]  decOp;
  reg         decDrain;
  reg         decWfi;
  reg         nxt_opValid;
  reg  [3:0]  nxt_opCode;
  reg         nxt_enterDebug;
  reg         nxt_irqWake;
  wire [7:0]  hitVec;
  wire        idleWrite;
  wire        regionWrite;
  wire        irqWakeReq;
  wire        dbgWakeReq;
  wire        opWaits;
  wire [31:0] opWord;

  ////////////////////////////////////////////////////////////////////////////
  // write decode helpers
  assign idleWrite   = cpWrite & (state_ff == ST_IDLE);
  // selector 1 writes are dropped so a stray one cannot corrupt a region
  assign regionWrite = idleWrite & (cpPrimary == `PCC_PRI_REGION) & ~cpSecondary[3] &
                       (cpSelector == `PCC_SEL0);
  // interrupt wake ignores the status-word masks
  assign irqWakeReq  = ~fast_irq_request_n | ~normal_irq_request_n;
  assign dbgWakeReq  = debug_permit & (external_debug_request | debugReqBit);
  // prefetch is no clean or flush, so it never waits for a linefetch
  assign opWaits     = linefetchBusy & (decOp != `PCC_OP_IPREFETCH);
  assign opWord      = (state_ff == ST_PEND) ? pendData_ff : cpWdata;

  ////////////////////////////////////////////////////////////////////////////
  // region registers: only enables reset, base and size are don't-care until enabled
  always @(posedge mclk) begin
    if (srst) begin
      regEn_ff <= 8'h00;
    end else if (regionWrite) begin
      regEn_ff[cpSecondary[2:0]] <= cpWdata[`PCC_EN_BIT];
    end
    if (regionWrite) begin
      regBase_ff[cpSecondary[2:0]] <= cpWdata[`PCC_BASE_RANGE];
      regSize_ff[cpSecondary[2:0]] <= cpWdata[`PCC_SIZE_RANGE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // region match per region; misaligned bases give a masked compare only
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gRegion
      wire [5:0]  sizeLog;
      wire [31:0] cmpMask;
      assign sizeLog = {1'b0, regSize_ff[gi]} + `PCC_SIZE_SHIFT;
      assign cmpMask = `PCC_ALL_ONES << sizeLog;
      // reserved size codes never match
      assign hitVec[gi] = protEnable_ff & regEn_ff[gi] & (regSize_ff[gi] >= `PCC_SIZE_MIN) &
                          (((chkAddr ^ {regBase_ff[gi], 12'h000}) & cmpMask) ==
                           `PCC_ZERO32);
    end
  endgenerate

  // registered so the check output comes from a flop
  always @(posedge mclk) begin
    if (srst) begin
      chkHit_ff <= 8'h00;
    end else begin
      chkHit_ff <= hitVec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register enable bit, lockdown and tcm region registers
  always @(posedge mclk) begin
    if (srst) begin
      protEnable_ff <= 1'b0;
      dLockLoad_ff  <= 1'b0;
      dLockSeg_ff   <= 2'b00;
      iLockLoad_ff  <= 1'b0;
      iLockSeg_ff   <= 2'b00;
      dtcmBase_ff   <= `PCC_BASE_RESET;
      dtcmSize_ff   <= dtcmSizeStrap;                                // sizes start at the straps
      itcmSize_ff   <= itcmSizeStrap;
    end else if (idleWrite) begin
      if ((cpPrimary == `PCC_PRI_CTRL) && (cpSecondary == `PCC_SEC_C0) &&
          (cpSelector == `PCC_SEL0)) begin
        protEnable_ff <= cpWdata[`PCC_PROT_EN_BIT];
      end
      if ((cpPrimary == `PCC_PRI_LOCKTCM) && (cpSecondary == `PCC_SEC_C0)) begin
        if (cpSelector == `PCC_SEL0) begin
          dLockLoad_ff <= cpWdata[`PCC_LOAD_BIT];
          dLockSeg_ff  <= cpWdata[`PCC_SEG_RANGE];
        end else if (cpSelector == `PCC_SEL1) begin
          iLockLoad_ff <= cpWdata[`PCC_LOAD_BIT];
          iLockSeg_ff  <= cpWdata[`PCC_SEG_RANGE];
        end
      end
      if ((cpPrimary == `PCC_PRI_LOCKTCM) && (cpSecondary == `PCC_SEC_C1)) begin
        if (cpSelector == `PCC_SEL0) begin
          dtcmBase_ff <= cpWdata[`PCC_BASE_RANGE];
          dtcmSize_ff <= cpWdata[`PCC_SIZE_RANGE];
        end else if (cpSelector == `PCC_SEL1) begin
          // instruction tcm base is fixed, only the size is kept
          itcmSize_ff <= cpWdata[`PCC_SIZE_RANGE];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer; unmapped reads return zero
  always @* begin
    rdMux = `PCC_ZERO32;
    case (cpPrimary)
      `PCC_PRI_CTRL: begin
        rdMux[`PCC_PROT_EN_BIT] = protEnable_ff;
      end
      `PCC_PRI_REGION: begin
        // selector 1 is the legacy read path
        if (((cpSelector == `PCC_SEL0) || (cpSelector == `PCC_SEL1)) &&
            (cpSecondary[3] == 1'b0)) begin
          rdMux[`PCC_BASE_RANGE] = regBase_ff[cpSecondary[2:0]];
          rdMux[`PCC_SIZE_RANGE] = regSize_ff[cpSecondary[2:0]];
          rdMux[`PCC_EN_BIT]     = regEn_ff[cpSecondary[2:0]];
        end
      end
      `PCC_PRI_LOCKTCM: begin
        if ((cpSecondary == `PCC_SEC_C0) && (cpSelector == `PCC_SEL0)) begin
          rdMux[`PCC_LOAD_BIT]  = dLockLoad_ff;
          rdMux[`PCC_SEG_RANGE] = dLockSeg_ff;
        end else if ((cpSecondary == `PCC_SEC_C0) && (cpSelector == `PCC_SEL1)) begin
          rdMux[`PCC_LOAD_BIT]  = iLockLoad_ff;
          rdMux[`PCC_SEG_RANGE] = iLockSeg_ff;
        end else if ((cpSecondary == `PCC_SEC_C1) && (cpSelector == `PCC_SEL0)) begin
          rdMux[`PCC_BASE_RANGE] = dtcmBase_ff;
          rdMux[`PCC_SIZE_RANGE] = dtcmSize_ff;
        end else if ((cpSecondary == `PCC_SEC_C1) && (cpSelector == `PCC_SEL1)) begin
          rdMux[`PCC_SIZE_RANGE] = itcmSize_ff;
        end
      end
      default: rdMux = `PCC_ZERO32;
    endcase
  end

  // read data is held until the next read
  always @(posedge mclk) begin
    if (srst) begin
      cpRdata_ff   <= `PCC_ZERO32;
      cpRdValid_ff <= 1'b0;
    end else begin
      cpRdValid_ff <= cpRead;
      if (cpRead) begin
        cpRdata_ff <= rdMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cache operation decode
  always @* begin
    decOp    = `PCC_OP_NONE;
    decDrain = 1'b0;
    decWfi   = 1'b0;
    if (cpPrimary == `PCC_PRI_CACHEOP) begin
      case ({cpSecondary, cpSelector})
        {`PCC_SEC_C5, `PCC_SEL0}:  decOp = `PCC_OP_IFLUSH_ALL;
        {`PCC_SEC_C5, `PCC_SEL1}:  decOp = `PCC_OP_IFLUSH_ADR;
        {`PCC_SEC_C13, `PCC_SEL1}: decOp = `PCC_OP_IPREFETCH;
        {`PCC_SEC_C6, `PCC_SEL0}:  decOp = `PCC_OP_DFLUSH_ALL;
        {`PCC_SEC_C6, `PCC_SEL1}:  decOp = `PCC_OP_DFLUSH_ADR;
        {`PCC_SEC_C10, `PCC_SEL1}: decOp = `PCC_OP_DCLEAN_ADR;
        {`PCC_SEC_C14, `PCC_SEL1}: decOp = `PCC_OP_DCLFL_ADR;
        {`PCC_SEC_C10, `PCC_SEL2}: decOp = `PCC_OP_DCLEAN_IDX;
        {`PCC_SEC_C14, `PCC_SEL2}: decOp = `PCC_OP_DCLFL_IDX;
        {`PCC_SEC_C10, `PCC_SEL4}: decDrain = 1'b1;
        {`PCC_SEC_C0, `PCC_SEL4}:  decWfi = 1'b1;
        default:                   decOp = `PCC_OP_NONE;
      endcase
    end else if ((cpPrimary == `PCC_PRI_COMPAT) && (cpSecondary == `PCC_SEC_C8) &&
                 (cpSelector == `PCC_SEL2)) begin
      decWfi = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always @* begin
    nxt_state      = state_ff;
    nxt_pendOp     = pendOp_ff;
    nxt_opValid    = 1'b0;
    nxt_opCode     = cacheOpCode_ff;
    nxt_enterDebug = 1'b0;
    nxt_irqWake    = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (cpWrite && decWfi) begin
          nxt_state = ST_WFI;
        end else if (cpWrite && decDrain) begin
          nxt_state = ST_DRAIN;
        end else if (cpWrite && (decOp != `PCC_OP_NONE)) begin
          if (opWaits) begin
            nxt_state  = ST_PEND;
            nxt_pendOp = decOp;
          end else begin
            nxt_opValid = 1'b1;
            nxt_opCode  = decOp;
          end
        end
      end
      ST_PEND: begin
        if (!linefetchBusy) begin
          nxt_state   = ST_IDLE;
          nxt_opValid = 1'b1;
          nxt_opCode  = pendOp_ff;
        end
      end
      ST_DRAIN: begin
        if (wbEmpty) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WFI: begin
        // debug wins when both arrive so debug state comes first
        if (dbgWakeReq) begin
          nxt_state      = ST_IDLE;
          nxt_enterDebug = 1'b1;
        end else if (irqWakeReq) begin
          nxt_state   = ST_IDLE;
          nxt_irqWake = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // the pending word is caught with the command; no reset, read only after a capture
  always @(posedge mclk) begin
    if (idleWrite) begin
      pendData_ff <= cpWdata;
    end
  end

  // sequencer flops and command outputs
  always @(posedge mclk) begin
    if (srst) begin
      state_ff          <= ST_IDLE;
      pendOp_ff         <= `PCC_OP_NONE;
      cpStall_ff        <= 1'b0;
      cacheOpValid_ff   <= 1'b0;
      cacheOpCode_ff    <= `PCC_OP_NONE;
      cacheOpAddr_ff    <= `PCC_ZERO32;
      cacheOpSegment_ff <= 2'b00;
      cacheOpIndex_ff   <= {(IDX_TOP-4){1'b0}};
      wbDrainReq_ff     <= 1'b0;
      coreHalt_ff       <= 1'b0;
      lowPower_ff       <= 1'b0;
      enterDebug_ff     <= 1'b0;
      irqWake_ff        <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      pendOp_ff       <= nxt_pendOp;
      // core stalls for every cycle that the sequencer is busy
      cpStall_ff      <= (nxt_state != ST_IDLE);
      cacheOpValid_ff <= nxt_opValid;
      cacheOpCode_ff  <= nxt_opCode;
      if (nxt_opValid) begin
        // address and index views are both taken from the same word
        cacheOpAddr_ff    <= opWord;
        cacheOpSegment_ff <= opWord[`PCC_IDXSEG_RANGE];
        cacheOpIndex_ff   <= opWord[IDX_TOP:`PCC_IDX_LSB];
      end
      // drain continues through the halt until the buffer is empty
      wbDrainReq_ff <= ((nxt_state == ST_DRAIN) ||
                        (nxt_state == ST_WFI)) && !wbEmpty;
      coreHalt_ff   <= (nxt_state == ST_WFI);
      lowPower_ff   <= (nxt_state == ST_WFI);
      enterDebug_ff <= nxt_enterDebug;
      irqWake_ff    <= nxt_irqWake;
    end
  end

endmodule // pcc_regs
`default_nettype wire

// *** sim/pcc_regs_asserts.sv ***
// port assertions for the protection and cache control registers
`timescale 1ns/1ns
`default_nettype none
`include "pcc_defines.vh"
module pcc_regs_asserts #(
  parameter IDX_TOP = 9
) (
  input wire               mclk,
  input wire               srst,
  input wire               cpWrite,
  input wire               cpRead,
  input wire [3:0]         cpPrimary,
  input wire [3:0]         cpSecondary,
  input wire [2:0]         cpSelector,
  input wire [31:0]        cpWdata,
  input wire               cpRdValid_ff,
  input wire               cpStall_ff,
  input wire               fast_irq_request_n,
  input wire               normal_irq_request_n,
  input wire               debug_permit,
  input wire               linefetchBusy,
  input wire               wbEmpty,
  input wire [7:0]         chkHit_ff,
  input wire               protEnable_ff,
  input wire               cacheOpValid_ff,
  input wire [3:0]         cacheOpCode_ff,
  input wire [1:0]         cacheOpSegment_ff,
  input wire [IDX_TOP-5:0] cacheOpIndex_ff,
  input wire               wbDrainReq_ff,
  input wire               coreHalt_ff,
  input wire               lowPower_ff,
  input wire               enterDebug_ff,
  input wire               irqWake_ff
);
  //////////////////////////////////////////////////////////////////////////////
  // accepted writes only: the stall flop lags one cycle behind a write
  reg        prevWr_ff;
  wire       acc = cpWrite && !cpStall_ff && !prevWr_ff;
  wire       cop = acc && cpPrimary == `PCC_PRI_CACHEOP;
  wire [6:0] cs  = {cpSecondary, cpSelector};
  always @(posedge mclk) begin
    prevWr_ff <= srst ? 1'h0 : cpWrite;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////////////
  // cs codes: 28 flush all, 52 index clean, 54 drain, 04 or 42 wait
  rd_valid_a: assert property (cpRead |=> cpRdValid_ff)
    else $error("read not answered");
  flush_all_a: assert property (
    cop && cs == 7'h28 && !linefetchBusy
    |=> cacheOpValid_ff && cacheOpCode_ff == `PCC_OP_IFLUSH_ALL)
    else $error("flush all not issued");
  index_seg_a: assert property (
    cop && cs == 7'h52 && !linefetchBusy
    |=> cacheOpSegment_ff == $past(cpWdata[31:30])
    && cacheOpIndex_ff == $past(cpWdata[IDX_TOP:5]))
    else $error("index or segment wrong");
  line_wait_a: assert property (
    cacheOpValid_ff && cacheOpCode_ff != `PCC_OP_IPREFETCH |-> !$past(linefetchBusy))
    else $error("cache op during linefetch");
  drain_stall_a: assert property (
    cop && cs == 7'h54 |=> cpStall_ff && wbDrainReq_ff == !$past(wbEmpty))
    else $error("drain did not stall");
  drain_end_a: assert property (
    wbDrainReq_ff && wbEmpty && !coreHalt_ff |=> !cpStall_ff && !wbDrainReq_ff)
    else $error("drain did not end");
  wfi_halt_a: assert property (
    acc && (cpPrimary == 4'h7 && cs == 7'h04 || cpPrimary == 4'hF && cs == 7'h42)
    |=> coreHalt_ff && lowPower_ff && cpStall_ff)
    else $error("wait did not halt");
  irq_wake_a: assert property (
    coreHalt_ff && !normal_irq_request_n
    |=> !coreHalt_ff && !lowPower_ff && (irqWake_ff || enterDebug_ff))
    else $error("irq did not wake");
  debug_gate_a: assert property (
    coreHalt_ff && fast_irq_request_n && normal_irq_request_n && !debug_permit
    |=> coreHalt_ff)
    else $error("woke without permit");
  prot_off_a: assert property (!protEnable_ff |=> chkHit_ff == 8'h00)
    else $error("hit while disabled");
endmodule // pcc_regs_asserts
`default_nettype wire

// *** sim/pcc_core_model.sv ***
// core model issuing coprocessor register transfers
`timescale 1ns/1ns
`default_nettype none
module pcc_core_model (
  input  wire        mclk,
  input  wire [31:0] cpRdata,
  output reg         cpWrite = 1'h0,
  output reg         cpRead = 1'h0,
  output reg  [3:0]  cpPrimary = 4'h0,
  output reg  [3:0]  cpSecondary = 4'h0,
  output reg  [2:0]  cpSelector = 3'h0,
  output reg  [31:0] cpWdata = 32'h0
);
  //////////////////////////////////////////////////////////////////////////////
  // one transfer: held over the sampling edge, data taken at the next low phase
  task xfer(input reg w, input reg [3:0] p, input reg [3:0] s, input reg [2:0] o,
            input reg [31:0] d, output reg [31:0] q);
    @(posedge mclk);
    cpWrite <= w;
    cpRead <= !w;
    cpPrimary <= p;
    cpSecondary <= s;
    cpSelector <= o;
    cpWdata <= d;
    @(posedge mclk);
    cpWrite <= 1'h0;
    cpRead <= 1'h0;
    cpWdata <= ~d; // released bus never shows a stale word
    @(negedge mclk);
    q = cpRdata;
  endtask
endmodule // pcc_core_model
`default_nettype wire

// *** sim/pcc_regs_tb_top.sv ***
// testbench for the protection and cache control registers
`timescale 1ns/1ns
`default_nettype none
module pcc_regs_tb_top;
  localparam IDX = 9;
  // {secondary, selector} of the nine cache ops, codes 1 to 9 in order
  localparam [62:0] OPS = {7'h72, 7'h52, 7'h71, 7'h51, 7'h31, 7'h30, 7'h69, 7'h29, 7'h28};
  reg            mclk = 1'h0;
  reg            srst = 1'h1;
  reg            irqN = 1'h1;
  reg            fiqN = 1'h1;
  reg            dbgReq = 1'h0;
  reg            dbgPermit = 1'h0;
  reg            dbgBit = 1'h0;
  reg            lfBusy = 1'h0;
  reg            wbEmpty = 1'h1;
  reg  [31:0]    chkAddr = 32'h0;
  reg  [31:0]    rdData;
  reg  [31:0]    opData;
  wire           cpWrite, cpRead, stall, protEn, opValid, drainReq, halt, lowPwr;
  wire           enterDbg, irqWake, dLoad, iLoad;
  wire [3:0]     cpPrimary, cpSecondary, opCode;
  wire [2:0]     cpSelector;
  wire [31:0]    cpWdata, cpRdata, opAddr;
  wire [7:0]     chkHit;
  wire [1:0]     opSeg, dSeg, iSeg;
  wire [IDX-5:0] opIdx;
  wire [4:0]     dtcmSz, itcmSz;
  wire [19:0]    dtcmBase;
  integer        errors = 0;
  integer        testsRun = 0;
  integer        i;
  //////////////////////////////////////////////////////////////////////////////
  always #25 mclk = ~mclk;
  pcc_core_model core_u (.mclk(mclk), .cpRdata(cpRdata), .cpWrite(cpWrite), .cpRead(cpRead),
    .cpPrimary(cpPrimary), .cpSecondary(cpSecondary), .cpSelector(cpSelector),
    .cpWdata(cpWdata));
  pcc_regs #(.IDX_TOP(IDX)) dut_u (.mclk(mclk), .srst(srst), .cpWrite(cpWrite),
    .cpRead(cpRead), .cpPrimary(cpPrimary), .cpSecondary(cpSecondary),
    .cpSelector(cpSelector), .cpWdata(cpWdata), .cpRdata_ff(cpRdata), .cpRdValid_ff(),
    .cpStall_ff(stall), .fast_irq_request_n(fiqN), .normal_irq_request_n(irqN),
    .external_debug_request(dbgReq), .debug_permit(dbgPermit), .debugReqBit(dbgBit),
    .linefetchBusy(lfBusy), .wbEmpty(wbEmpty), .dtcmSizeStrap(5'h06), .itcmSizeStrap(5'h07),
    .chkAddr(chkAddr), .chkHit_ff(chkHit), .protEnable_ff(protEn), .cacheOpValid_ff(opValid),
    .cacheOpCode_ff(opCode), .cacheOpAddr_ff(opAddr), .cacheOpSegment_ff(opSeg),
    .cacheOpIndex_ff(opIdx), .wbDrainReq_ff(drainReq), .coreHalt_ff(halt),
    .lowPower_ff(lowPwr), .enterDebug_ff(enterDbg), .irqWake_ff(irqWake),
    .dLockLoad_ff(dLoad), .dLockSeg_ff(dSeg), .iLockLoad_ff(iLoad), .iLockSeg_ff(iSeg),
    .dtcmBase_ff(dtcmBase), .dtcmSize_ff(dtcmSz), .itcmSize_ff(itcmSz));
  //////////////////////////////////////////////////////////////////////////////
  // checking and access helpers
  task cmp(input reg [31:0] got, input reg [31:0] exp);
    testsRun = testsRun + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task testDone;
    if (errors == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task tmo(input reg bad);
    if (bad) begin
      errors = errors + 1;
      testDone;
    end
  endtask
  task wr(input reg [3:0] p, input reg [3:0] s, input reg [2:0] o, input reg [31:0] d);
    core_u.xfer(1'h1, p, s, o, d, rdData);
  endtask
  task rdc(input reg [3:0] p, input reg [3:0] s, input reg [2:0] o, input reg [31:0] e);
    core_u.xfer(1'h0, p, s, o, 32'h0, rdData);
    cmp(rdData, e);
  endtask
  // hit is registered, so look one full cycle after the address settles
  task hit(input reg [31:0] a, input reg [7:0] e);
    @(posedge mclk);
    chkAddr <= a;
    @(posedge mclk);
    @(negedge mclk);
    cmp(32'(chkHit), 32'(e));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // hang guard well above the real run length
  initial begin
    repeat (20000) @(posedge mclk);
    tmo(1'h1);
  end
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'h0;
    @(negedge mclk);
    cmp(32'({protEn, dtcmSz, itcmSz}), 32'h0C7);
    core_u.xfer(1'h0, 4'h6, 4'h0, 3'h0, 32'h0, rdData);
    cmp(rdData & 32'h1, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      wr(4'h6, i[3:0], 3'h0, 32'h00002019 + (i << 20));
    end
    for (i = 0; i < 8; i = i + 1) begin
      rdc(4'h6, i[3:0], 3'h0, 32'h00002019 + (i << 20));
      rdc(4'h6, i[3:0], 3'h1, 32'h00002019 + (i << 20));
    end
    // refused on purpose: region write with selector 1 must not land
    wr(4'h6, 4'h0, 3'h1, 32'h0);
    rdc(4'h6, 4'h0, 3'h0, 32'h00002019);
    rdc(4'h2, 4'h0, 3'h0, 32'h0);
    hit(32'h00103FFC, 8'h00);
    wr(4'h1, 4'h0, 3'h0, 32'h1);
    hit(32'h00103FFC, 8'h02);
    hit(32'h00104000, 8'h00);
    for (i = 0; i < 9; i = i + 1) begin
      opData = (i == 0 || i == 3) ? 32'h0 : (i > 6 ? 32'hC0000000 : 32'h0) | (i << 5);
      wr(4'h7, OPS[7*i+3 +: 4], OPS[7*i +: 3], opData);
      cmp(32'({opValid, opCode}), 32'h11 + i);
      if (i > 6) cmp(32'({opSeg, opIdx}), 32'h60 + i);
      else if (i != 0 && i != 3) cmp(opAddr, opData);
    end
    @(posedge mclk);
    lfBusy <= 1'h1;
    wr(4'h7, 4'h6, 3'h0, 32'h0);
    cmp(32'({stall, opValid}), 32'h2);
    repeat (3) @(posedge mclk);
    lfBusy <= 1'h0;
    for (i = 0; i < 10 && opValid !== 1'h1; i = i + 1) @(negedge mclk);
    tmo(opValid !== 1'h1);
    cmp(32'(opCode), 32'h4);
    @(posedge mclk);
    wbEmpty <= 1'h0;
    wr(4'h7, 4'hA, 3'h4, 32'h0);
    repeat (4) @(negedge mclk);
    cmp(32'({stall, drainReq}), 32'h3);
    @(posedge mclk);
    wbEmpty <= 1'h1;
    repeat (2) @(negedge mclk);
    cmp(32'(stall), 32'h0);
    // wait with debug bit raised but not permitted, then woken by irq
    @(posedge mclk);
    wbEmpty <= 1'h0;
    dbgBit <= 1'h1;
    wr(4'h7, 4'h0, 3'h4, 32'h0);
    repeat (3) @(negedge mclk);
    cmp(32'({halt, lowPwr, stall, drainReq}), 32'hF);
    @(posedge mclk);
    wbEmpty <= 1'h1;
    dbgBit <= 1'h0;
    irqN <= 1'h0;
    repeat (2) @(negedge mclk);
    cmp(32'({halt, irqWake, enterDbg}), 32'h2);
    @(posedge mclk);
    irqN <= 1'h1;
    dbgPermit <= 1'h1;
    wr(4'hF, 4'h8, 3'h2, 32'h0);
    cmp(32'({halt, lowPwr}), 32'h3);
    @(posedge mclk);
    dbgReq <= 1'h1;
    repeat (2) @(negedge mclk);
    cmp(32'({halt, irqWake, enterDbg}), 32'h1);
    @(posedge mclk);
    dbgReq <= 1'h0;
    // fast interrupt alone also ends the wait
    wr(4'h7, 4'h0, 3'h4, 32'h0);
    @(posedge mclk);
    fiqN <= 1'h0;
    repeat (2) @(negedge mclk);
    cmp(32'({halt, irqWake, enterDbg}), 32'h2);
    @(posedge mclk);
    fiqN <= 1'h1;
    wr(4'h9, 4'h0, 3'h0, 32'hFFFFFFFE);
    rdc(4'h9, 4'h0, 3'h0, 32'h80000002);
    wr(4'h9, 4'h0, 3'h1, 32'h80000001);
    rdc(4'h9, 4'h0, 3'h1, 32'h80000001);
    cmp(32'({dLoad, dSeg, iLoad, iSeg}), 32'h35);
    wr(4'h9, 4'h1, 3'h0, 32'h00010000);
    cmp(32'(dtcmBase), 32'h10);
    testDone;
  end
endmodule // pcc_regs_tb_top
bind pcc_regs pcc_regs_asserts #(.IDX_TOP(IDX_TOP)) chk_u (.mclk(mclk), .srst(srst),
  .cpWrite(cpWrite), .cpRead(cpRead), .cpPrimary(cpPrimary), .cpSecondary(cpSecondary),
  .cpSelector(cpSelector), .cpWdata(cpWdata), .cpRdValid_ff(cpRdValid_ff),
  .cpStall_ff(cpStall_ff), .fast_irq_request_n(fast_irq_request_n),
  .normal_irq_request_n(normal_irq_request_n), .debug_permit(debug_permit),
  .linefetchBusy(linefetchBusy), .wbEmpty(wbEmpty), .chkHit_ff(chkHit_ff),
  .protEnable_ff(protEnable_ff), .cacheOpValid_ff(cacheOpValid_ff),
  .cacheOpCode_ff(cacheOpCode_ff), .cacheOpSegment_ff(cacheOpSegment_ff),
  .cacheOpIndex_ff(cacheOpIndex_ff), .wbDrainReq_ff(wbDrainReq_ff), .coreHalt_ff(coreHalt_ff),
  .lowPower_ff(lowPower_ff), .enterDebug_ff(enterDebug_ff), .irqWake_ff(irqWake_ff));
`default_nettype wire
